// ---- logic/lnsb_lin_setup.sv ----
// LIN node setup: APB registers, indirect window, baud generator and bit streamer
// Overview of operation
// - Bit rate is clock over 2^(prescaler+1), divider, and multiplier+1.
// - Prescaler 0..3, multiplier 0..31, divider 200..511 accepted.
// - Factors live in baud divider and multiplier registers behind the window.
// - Controller needs a system clock of at least 8 MHz.
// - Bit six of control-mode register picks master or slave.
// - Bit five picks auto baud; only slaves may use it.
// - Other registers reached indirectly; address register selects data target.
// - Bit seven activates interface; bit six makes it master.
// - Index 0x0D holds prescaler 7:6, multiplier 5:1, divider bit 8.
// - Index 0x0C holds divider low eight bits.
// - Checksum always classic; size register bit seven is stored but not used.
// - Writing 0x0C to control register clears errors and interrupt.
// - State machine streams message bytes and governs bit timing.
// - Message bytes kept in core-accessible data registers.
// - Completion and error status reported for interrupt or polling.
// - Slave auto baud uses prescaler and divider only, divider per 20000.
`timescale 1ns/10ps
`include "lnsb_consts.svh"
module lnsb_lin_setup
    import lnsb_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // LIN pin, open drain
    input  wire logic        linRx,
    output logic             linTx,
    output logic             linTxOe,
    // Interrupt
    output logic             irq
);
    // ========================================
    // Registers
    logic [7:0]  controlMode;
    logic [7:0]  indAddr;
    logic [7:0]  divLow;
    logic [7:0]  mulReg;
    logic [7:0]  sizeReg;
    logic [7:0]  ctrlReg;
    logic [7:0]  dataBuf [0:7];
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        factorErr;
    logic        rxMeta;
    logic        rxSync;
    logic        bitTick;
    lnsb_baud_t  factors;
    lnsb_state_t state;
    logic [2:0]  bitCnt;
    logic [2:0]  byteCnt;
    logic [7:0]  shiftReg;
    logic [7:0]  checksum;
    logic [8:0]  checkSum9;
    logic        sendChk;
    logic        evDone;
    logic        evErr;
    logic        wrAcc;
    logic        rdAcc;
    logic        wrData;
    logic        autoBaud;
    logic        ifaceOn;
    logic [3:0]  frameLen;

    // Clock floor check: the core clock is fixed, so this is an elaboration fact
    localparam logic CLK_OK = (`LNSB_SYSCLK_HZ >= `LNSB_SYSCLK_MIN_HZ);
    // Auto-baud base count, core clock over the auto rate, before the prescaler+1 shift
    localparam int AUTO_BASE = `LNSB_SYSCLK_HZ / `LNSB_AUTO_RATE;

    assign wrAcc    = psel && penable && pwrite;
    assign rdAcc    = psel && penable && !pwrite;
    assign wrData   = wrAcc && (paddr == `LNSB_ADDR_INDDATA);
    // Auto baud honoured only in slave mode
    assign autoBaud = controlMode[`LNSB_MODE_AUTO_BAUD_SELECT] && !controlMode[`LNSB_MODE_MASTER];
    assign ifaceOn  = controlMode[`LNSB_MODE_ACTIVE] && CLK_OK;
    assign frameLen = (sizeReg[3:0] == 4'h0 || sizeReg[3:0] > 4'h8) ? 4'h8 : sizeReg[3:0];

    // ========================================
    // Baud factor assembly
    always_comb begin
        factors.prescaler  = mulReg[`LNSB_MUL_PRE_HI:`LNSB_MUL_PRE_LO];
        factors.multiplier = mulReg[`LNSB_MUL_MUL_HI:`LNSB_MUL_MUL_LO];
        factors.divider    = {mulReg[`LNSB_MUL_DIV8], divLow};
        if (autoBaud) begin
            factors.multiplier = 5'h00;
            // Shift count widened so a prescaler of three does not wrap to zero
            factors.divider    = 9'(AUTO_BASE >> ({1'b0, factors.prescaler} + 3'h1));
        end
        // Out-of-range divider would run too fast, so it is held at the floor
        if (factors.divider < `LNSB_DIV_MIN) begin
            factors.divider = `LNSB_DIV_MIN;
        end
    end
    assign factorErr = ({mulReg[`LNSB_MUL_DIV8], divLow} < `LNSB_DIV_MIN) && !autoBaud;

    lnsb_baud_gen i_lnsb_baud_gen (
        .core_clk (core_clk),
        .rst      (rst),
        .enable   (ifaceOn),
        .factors  (factors),
        .bitTick  (bitTick)
    );

    // ========================================
    // Pin synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
        end else begin
            rxMeta <= linRx;
            rxSync <= rxMeta;
        end
    end

    // ========================================
    // Direct registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            controlMode <= 8'h00;
            indAddr     <= 8'h00;
            mask        <= 2'b00;
        end else if (wrAcc) begin
            case (paddr)
                `LNSB_ADDR_MODE: begin
                    controlMode <= pwdata[7:0];
                end
                `LNSB_ADDR_INDADDR: begin
                    indAddr <= pwdata[7:0];
                end
                `LNSB_ADDR_MASK: begin
                    mask <= pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================
    // Indirect registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            divLow  <= 8'(`LNSB_DIV_RESET);
            mulReg  <= `LNSB_MUL_RESET;
            sizeReg <= 8'h00;
            ctrlReg <= 8'h00;
        end else begin
            // Start request self-clears once the frame begins
            if (state == LNSB_START) begin
                ctrlReg[`LNSB_CTRL_START] <= 1'b0;
            end
            if (wrData) begin
                case (indAddr)
                    `LNSB_IDX_DIV:  divLow  <= pwdata[7:0];
                    `LNSB_IDX_MUL:  mulReg  <= pwdata[7:0];
                    `LNSB_IDX_SIZE: sizeReg <= pwdata[7:0];
                    `LNSB_IDX_CTRL: ctrlReg <= pwdata[7:0] & ~`LNSB_CTRL_CLRCMD;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ========================================
    // Message data buffer
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_buf
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    dataBuf[gi] <= 8'h00;
                end else if (wrData && indAddr == 8'(gi)) begin
                    dataBuf[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // ========================================
    // Bit streamer: start bit, eight data bits LSB first, stop bit
    assign checkSum9 = {1'b0, checksum} + {1'b0, shiftReg};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state    <= LNSB_IDLE;
            bitCnt   <= 3'h0;
            byteCnt  <= 3'h0;
            shiftReg <= 8'h00;
            checksum <= 8'h00;
            sendChk  <= 1'b0;
            linTx    <= 1'b1;
            linTxOe  <= 1'b1;
            evDone   <= 1'b0;
            evErr    <= 1'b0;
        end else begin
            evDone <= 1'b0;
            evErr  <= 1'b0;
            if (!ifaceOn) begin
                state   <= LNSB_IDLE;
                linTx   <= 1'b1;
                linTxOe <= 1'b1;
            end else begin
                case (state)
                    LNSB_IDLE: begin
                        linTx   <= 1'b1;
                        linTxOe <= 1'b1;
                        if (ctrlReg[`LNSB_CTRL_START]) begin
                            byteCnt  <= 3'h0;
                            sendChk  <= 1'b0;
                            shiftReg <= dataBuf[0];
                            // Enhanced form seeds with the identifier; none held here
                            checksum <= 8'h00;
                            state    <= LNSB_START;
                        end
                    end
                    LNSB_START: begin
                        if (bitTick) begin
                            linTx   <= 1'b0;
                            linTxOe <= 1'b0;
                            bitCnt  <= 3'h0;
                            state   <= LNSB_DATA;
                        end
                    end
                    LNSB_DATA: begin
                        if (bitTick) begin
                            linTx   <= shiftReg[bitCnt];
                            // A one is recessive, so the pin is released for it
                            linTxOe <= shiftReg[bitCnt];
                            bitCnt  <= 3'(bitCnt + 3'h1);
                            // Bus readback: a low seen when we release is a collision
                            if (linTxOe == 1'b1 && !rxSync && state == LNSB_DATA
                                && bitCnt != 3'h0) begin
                                evErr <= 1'b1;
                            end
                            if (bitCnt == 3'h7) begin
                                state <= LNSB_STOP;
                            end
                        end
                    end
                    LNSB_STOP: begin
                        if (bitTick) begin
                            linTx   <= 1'b1;
                            linTxOe <= 1'b1;
                            if (sendChk) begin
                                evDone <= 1'b1;
                                state  <= LNSB_IDLE;
                            end else begin
                                // Carry folds back in, as both checksum forms require
                                checksum <= 8'(checkSum9[7:0] + {7'h00, checkSum9[8]});
                                if (4'(byteCnt + 3'h1) == frameLen) begin
                                    sendChk  <= 1'b1;
                                    shiftReg <= ~8'(checkSum9[7:0] + {7'h00, checkSum9[8]});
                                end else begin
                                    shiftReg <= dataBuf[3'(byteCnt + 3'h1)];
                                end
                                byteCnt <= 3'(byteCnt + 3'h1);
                                state   <= LNSB_START;
                            end
                        end
                    end
                    default: begin
                        state <= LNSB_IDLE;
                    end
                endcase
            end
        end
    end

    // ========================================
    // Sticky status; a new event wins over the clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wrAcc && paddr == `LNSB_ADDR_STATUS && pwdata[i]) begin
                    status[i] <= 1'b0;
                end
                if (wrData && indAddr == `LNSB_IDX_CTRL && pwdata[7:0] == `LNSB_CTRL_CLRCMD) begin
                    status[i] <= 1'b0;
                end
            end
            if (evDone) begin
                status[`LNSB_ST_DONE] <= 1'b1;
            end
            if (evErr || (factorErr && ifaceOn)) begin
                status[`LNSB_ST_ERR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // ========================================
    // APB read path, no wait states
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `LNSB_ADDR_MODE:     prdata <= {24'h0, controlMode};
                    `LNSB_ADDR_INDADDR:  prdata <= {24'h0, indAddr};
                    `LNSB_ADDR_STATUS:   prdata <= {30'h0, status};
                    `LNSB_ADDR_MASK:     prdata <= {30'h0, mask};
                    `LNSB_ADDR_BAUDSTAT: prdata <= {16'h0, factors};
                    `LNSB_ADDR_INDDATA: begin
                        if (indAddr <= `LNSB_IDX_DATA_LAST) begin
                            prdata <= {24'h0, dataBuf[indAddr[2:0]]};
                        end else begin
                            case (indAddr)
                                `LNSB_IDX_CTRL: prdata <= {24'h0, ctrlReg};
                                `LNSB_IDX_SIZE: prdata <= {24'h0, sizeReg};
                                `LNSB_IDX_DIV:  prdata <= {24'h0, divLow};
                                `LNSB_IDX_MUL:  prdata <= {24'h0, mulReg};
                                default:        prdata <= 32'h0000_0000;
                            endcase
                        end
                    end
                    default: pslverr <= 1'b1;
                endcase
            end else if (psel && !penable && pwrite) begin
                case (paddr)
                    `LNSB_ADDR_MODE, `LNSB_ADDR_INDADDR, `LNSB_ADDR_INDDATA,
                    `LNSB_ADDR_STATUS, `LNSB_ADDR_MASK, `LNSB_ADDR_BAUDSTAT: pslverr <= 1'b0;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // lnsb_lin_setup

// ---- logic/lnsb_consts.svh ----
// Register offsets, field positions, reset values and timing figures for the LIN setup block
`ifndef LNSB_CONSTS_SVH
`define LNSB_CONSTS_SVH
// APB byte addresses
`define LNSB_ADDR_MODE      12'h000
`define LNSB_ADDR_INDADDR   12'h004
`define LNSB_ADDR_INDDATA   12'h008
`define LNSB_ADDR_STATUS    12'h00c
`define LNSB_ADDR_MASK      12'h010
`define LNSB_ADDR_BAUDSTAT  12'h014
// Indirect indices
`define LNSB_IDX_DATA_LAST  8'h07
`define LNSB_IDX_CTRL       8'h08
`define LNSB_IDX_SIZE       8'h0b
`define LNSB_IDX_DIV        8'h0c
`define LNSB_IDX_MUL        8'h0d
// Control-mode bits
`define LNSB_MODE_ACTIVE    7
`define LNSB_MODE_MASTER    6
`define LNSB_MODE_AUTO_BAUD_SELECT     5
// Control register bits and clear command
`define LNSB_CTRL_CLRCMD    8'h0c
`define LNSB_CTRL_RSTINT    3
`define LNSB_CTRL_RSTERR    2
`define LNSB_CTRL_START     0
`define LNSB_SIZE_ENH       7
// Multiplier register fields
`define LNSB_MUL_PRE_HI     7
`define LNSB_MUL_PRE_LO     6
`define LNSB_MUL_MUL_HI     5
`define LNSB_MUL_MUL_LO     1
`define LNSB_MUL_DIV8       0
// Factor limits and reset values
`define LNSB_DIV_MIN        9'h0c8
`define LNSB_DIV_RESET      9'h0c8
`define LNSB_MUL_RESET      8'h00
// Status bits
`define LNSB_ST_DONE        0
`define LNSB_ST_ERR         1
// Auto-baud figures
`define LNSB_AUTO_RATE      20000
`define LNSB_SYSCLK_MIN_HZ  8000000
`define LNSB_SYSCLK_HZ      100000000
`endif

// ---- logic/lnsb_pkg.sv ----
// Types shared by the LIN setup block
package lnsb_pkg;
    typedef struct packed {
        logic [1:0] prescaler;
        logic [8:0] divider;
        logic [4:0] multiplier;
    } lnsb_baud_t;

    typedef enum logic [3:0] {
        LNSB_IDLE  = 4'b0001,
        LNSB_START = 4'b0010,
        LNSB_DATA  = 4'b0100,
        LNSB_STOP  = 4'b1000
    } lnsb_state_t;
endpackage

// ---- logic/lnsb_baud_gen.sv ----
// Cascaded prescale, divider and multiplier counters giving the bit tick
`timescale 1ns/10ps
module lnsb_baud_gen
    import lnsb_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       enable,
    input  lnsb_baud_t      factors,
    // Tick
    output logic            bitTick
);
    logic [3:0] preCnt;
    logic [8:0] divCnt;
    logic [4:0] mulCnt;
    logic [3:0] preTop;
    logic       preEnd;
    logic       divEnd;
    logic       mulEnd;

    // Power-of-two prescale: 2^(p+1) clocks
    assign preTop = 4'((4'h2 << factors.prescaler) - 4'h1);
    assign preEnd = (preCnt == preTop);
    assign divEnd = preEnd && (divCnt == 9'(factors.divider - 9'h001));
    assign mulEnd = divEnd && (mulCnt == factors.multiplier);

    // ========================================
    // Counter cascade, each reloads on terminal count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            preCnt <= 4'h0;
            divCnt <= 9'h000;
            mulCnt <= 5'h00;
        end else if (!enable) begin
            preCnt <= 4'h0;
            divCnt <= 9'h000;
            mulCnt <= 5'h00;
        end else begin
            preCnt <= preEnd ? 4'h0 : 4'(preCnt + 4'h1);
            if (preEnd) begin
                divCnt <= divEnd ? 9'h000 : 9'(divCnt + 9'h001);
            end
            if (divEnd) begin
                mulCnt <= mulEnd ? 5'h00 : 5'(mulCnt + 5'h01);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bitTick <= 1'b0;
        end else begin
            bitTick <= enable && mulEnd;
        end
    end
endmodule // lnsb_baud_gen

// ---- tb/lnsb_lin_setup_properties.sv ----
// Port-level checks of the LIN setup block
`timescale 1ns/10ps
`include "lnsb_consts.svh"
module lnsb_lin_setup_properties
    import lnsb_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // LIN pin and interrupt
    input wire logic        linRx,
    input wire logic        linTx,
    input wire logic        linTxOe,
    input wire logic        irq
);
    // ==========================================
    // Mirror of the interface-active bit
    logic modeOn;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modeOn <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == `LNSB_ADDR_MODE) begin
            modeOn <= pwdata[`LNSB_MODE_ACTIVE];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Assertions
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable && paddr > `LNSB_ADDR_BAUDSTAT
        |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && !penable && paddr <= `LNSB_ADDR_BAUDSTAT
        && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    drive_low_a: assert property (!linTxOe |-> !linTx)
        else $error("driving a recessive level");
    idle_release_a: assert property (!modeOn |=> linTxOe)
        else $error("pin driven while inactive");
    start_hold_a: assert property ($fell(linTxOe) |-> !linTxOe [*8])
        else $error("dominant bit too short");
    bit_hold_a: assert property ($rose(linTxOe) && modeOn |-> linTxOe [*8])
        else $error("recessive bit too short");
    // ==========================================
    // Covers
    frame_c: cover property ($fell(linTxOe));
    irq_c: cover property ($rose(irq));
    refuse_c: cover property (pslverr);
endmodule // lnsb_lin_setup_properties

bind lnsb_lin_setup lnsb_lin_setup_properties i_lnsb_lin_setup_properties (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linRx(linRx), .linTx(linTx), .linTxOe(linTxOe), .irq(irq)
);

// ---- tb/lnsb_bus_node.sv ----
// Other node on the shared LIN wire, with pull-up
`timescale 1ns/10ps
module lnsb_bus_node (
    // Device pin
    input  wire logic devTx,
    input  wire logic devTxOe,
    // Collision request from the bench
    input  wire logic forceLow,
    // Resolved wire
    output logic      busLevel
);
    // ==========================================
    // Wired-AND: any dominant driver wins, otherwise the pull-up holds it high
    assign busLevel = !((!devTxOe && !devTx) || forceLow);
endmodule // lnsb_bus_node

// ---- tb/lnsb_lin_setup_bench.sv ----
// Self-checking bench of the LIN setup block
`timescale 1ns/10ps
`include "lnsb_consts.svh"
`define CHK(nm, e, a) begin checkCount++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module lnsb_lin_setup_bench;
    import lnsb_pkg::*;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic        linTx, linTxOe, irq, forceLow, busLevel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  b;
    int          fails, checkCount, n;

    lnsb_lin_setup i_lnsb_lin_setup (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .linRx(busLevel),
        .linTx(linTx), .linTxOe(linTxOe), .irq(irq));
    lnsb_bus_node i_lnsb_bus_node (.devTx(linTx), .devTxOe(linTxOe),
        .forceLow(forceLow), .busLevel(busLevel));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ==========================================
    // Closing report
    task give_verdict;
        $display("Checks %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One APB transfer; read data taken at the pready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin fails++; give_verdict; end
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task ind(input logic w, input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, `LNSB_ADDR_INDADDR, {24'h0, idx});
        apb(w, `LNSB_ADDR_INDDATA, {24'h0, d});
    endtask
    // Wait for the next start bit; optionally check its length; sample mid-bit
    task get_byte(input int expLen);
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (busLevel !== 1'b0 && n < 20000);
        if (n >= 20000) begin fails++; give_verdict; end
        // Mid bit 0 lies 600 clocks after the start edge; the length check counts to the first rise, so it needs bit 0 to be one
        if (expLen > 0) begin
            n = 0;
            do begin @(posedge core_clk); #1; n++; end while (busLevel !== 1'b1 && n < 5000);
            `CHK("start bit length", expLen, n)
            repeat (600 - n) @(posedge core_clk);
        end else begin
            repeat (600) @(posedge core_clk);
        end
        #1 b[0] = busLevel;
        for (int i = 1; i < 8; i++) begin
            repeat (400) @(posedge core_clk);
            #1 b[i] = busLevel;
        end
        repeat (400) @(posedge core_clk);
        #1 `CHK("stop bit", 1'b1, busLevel)
    endtask
    task wait_status(input logic [31:0] bitMask);
        n = 0;
        do begin repeat (50) @(posedge core_clk); apb(1'b0, `LNSB_ADDR_STATUS, 0); end
        while ((rd & bitMask) == 0 && n++ < 400);
        `CHK("status", bitMask, rd & bitMask)
        if ((rd & bitMask) == 0) give_verdict;
    endtask

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; forceLow = 1'b0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        // ==========================================
        // Reset factors, indirect reads, unmapped refusal
        apb(1'b0, `LNSB_ADDR_BAUDSTAT, 0);
        `CHK("reset factors", 32'h00001900, rd)
        ind(1'b0, `LNSB_IDX_DIV, 8'h00);
        `CHK("div reset", 32'h000000c8, rd)
        ind(1'b0, `LNSB_IDX_MUL, 8'h00);
        `CHK("mul reset", 32'h00000000, rd)
        apb(1'b0, 12'h020, 0);
        `CHK("unmapped read", 32'h0, rd)
        $display("test reset done");
        // Field placement: prescaler 1, multiplier 1, divider 0x138
        ind(1'b1, `LNSB_IDX_MUL, 8'h43);
        ind(1'b1, `LNSB_IDX_DIV, 8'h38);
        apb(1'b0, `LNSB_ADDR_BAUDSTAT, 0);
        `CHK("factors", 32'h00006701, rd)
        // Divider below the floor, and master ignores auto baud
        ind(1'b1, `LNSB_IDX_MUL, 8'h02);
        ind(1'b1, `LNSB_IDX_DIV, 8'h10);
        apb(1'b0, `LNSB_ADDR_BAUDSTAT, 0);
        `CHK("clamped divider", 32'h00001901, rd)
        apb(1'b1, `LNSB_ADDR_MODE, 32'he0);
        ind(1'b1, `LNSB_IDX_DIV, 8'hc8);
        apb(1'b0, `LNSB_ADDR_BAUDSTAT, 0);
        `CHK("master manual", 32'h00001901, rd)
        // Slave auto baud, prescaler 3: divider 100 MHz / (16 * 20000) = 312
        ind(1'b1, `LNSB_IDX_MUL, 8'hc0);
        apb(1'b1, `LNSB_ADDR_MODE, 32'ha0);
        apb(1'b0, `LNSB_ADDR_BAUDSTAT, 0);
        `CHK("slave auto", 32'h0000e700, rd)
        $display("test factors done");
        // ==========================================
        // One-byte frame at 400 clocks a bit, done flag masked then unmasked
        ind(1'b1, `LNSB_IDX_MUL, 8'h00);
        apb(1'b1, `LNSB_ADDR_MODE, 32'hc0);
        apb(1'b1, `LNSB_ADDR_STATUS, 32'h3);
        apb(1'b1, `LNSB_ADDR_MASK, 32'h0);
        ind(1'b1, `LNSB_IDX_SIZE, 8'h81);
        ind(1'b1, 8'h00, 8'h55);
        ind(1'b1, `LNSB_IDX_CTRL, 8'h01);
        get_byte(400);
        `CHK("data byte", 8'h55, b)
        get_byte(0);
        `CHK("checksum", 8'haa, b)
        wait_status(32'h1);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, `LNSB_ADDR_MASK, 32'h3);
        repeat (2) @(posedge core_clk);
        `CHK("irq unmasked", 1'b1, irq)
        apb(1'b1, `LNSB_ADDR_STATUS, 32'h1);
        apb(1'b0, `LNSB_ADDR_STATUS, 0);
        `CHK("done cleared", 32'h0, rd)
        `CHK("irq cleared", 1'b0, irq)
        $display("test frame done");
        // ==========================================
        // Collision in a released data bit, then the clear command
        ind(1'b1, `LNSB_IDX_CTRL, 8'h01);
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (busLevel !== 1'b0 && n < 2000);
        if (n >= 2000) begin fails++; give_verdict; end
        repeat (500) @(posedge core_clk);
        // Held across the end of the released bit, where the readback is sampled
        forceLow <= 1'b1;
        repeat (400) @(posedge core_clk);
        forceLow <= 1'b0;
        wait_status(32'h2);
        `CHK("irq on error", 1'b1, irq)
        apb(1'b1, `LNSB_ADDR_MODE, 32'h00);
        ind(1'b1, `LNSB_IDX_CTRL, `LNSB_CTRL_CLRCMD);
        apb(1'b0, `LNSB_ADDR_STATUS, 0);
        `CHK("cleared by command", 32'h0, rd)
        `CHK("irq after command", 1'b0, irq)
        `CHK("released", 1'b1, busLevel)
        $display("test collision done");
        give_verdict;
    end
endmodule // lnsb_lin_setup_bench
